/* File: fsp_self_prog.sv */
// Self-programming controller: section checks, locks, stall and busy flag.
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
// How it works
// - Boot size fuses split flash into application and boot sections.
// - Application lock bits govern program and read access to application.
// - Store-program from the application section is rejected.
// - Programming starts only when the instruction sits in boot code.
// - From boot code any page may be targeted, locks permitting.
// - Boot lock bits govern accesses to the boot code section.
// - Both lock pairs are written and held independently.
// - A fixed boundary splits flash into concurrent and stalling regions.
// - Stall or not depends on the page programmed, not fetched.
// - Programming the concurrent region keeps stalling-region fetches.
// - Programming the stalling region halts the CPU throughout.
// - Erase and write act on whole pages; fetches ignore pages.
// - Busy flag reads one while blocked; software clears it afterwards.
module fsp_self_prog #(
	parameter int FLASH_WORDS = fsp_pkg::FLASH_WORDS,
	parameter int BOOT_MIN_WORDS = fsp_pkg::BOOT_MIN_WORDS,
	parameter int RWW_LIMIT = fsp_pkg::RWW_LIMIT
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [1:0] boot_size_fuses_i,
	input wire logic [fsp_pkg::RAW-1:0] reg_addr_i,
	input wire logic [fsp_pkg::DW-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [fsp_pkg::DW-1:0] reg_rdata_o,
	input wire logic store_prog_req_i,
	input wire fsp_pkg::fsp_op_type store_prog_op_i,
	input wire logic [fsp_pkg::AW-1:0] store_prog_pc_i,
	input wire logic [fsp_pkg::AW-1:0] store_prog_addr_i,
	output logic store_prog_ack_o,
	output logic store_prog_reject_o,
	output logic store_prog_done_o,
	input wire logic load_req_i,
	input wire logic [fsp_pkg::AW-1:0] load_pc_i,
	input wire logic [fsp_pkg::AW-1:0] load_addr_i,
	output logic load_deny_o,
	input wire logic fetch_req_i,
	input wire logic [fsp_pkg::AW-1:0] fetch_addr_i,
	output logic fetch_grant_o,
	output logic fetch_violation_o,
	output logic flash_erase_o,
	output logic flash_write_o,
	output logic [fsp_pkg::AW-fsp_pkg::PAGE_SH-1:0] flash_page_o,
	output logic cpu_stall_o,
	output logic concurrent_region_busy_flag_o
);
	import fsp_pkg::*;

	localparam int NCLS = 5;
	localparam int C_PC = 0;
	localparam int C_TGT = 1;
	localparam int C_LDPC = 2;
	localparam int C_LDA = 3;
	localparam int C_FET = 4;
	localparam int PW = AW - PAGE_SH;

	typedef enum logic {
		FSP_IDLE,
		FSP_BUSY
	} fsp_state_type;

	// ****************************************************************
	// Address classification
	// ****************************************************************
	logic [AW-1:0] cls_addr [NCLS];
	logic [NCLS-1:0] cls_boot;
	logic [NCLS-1:0] cls_stall;

	assign cls_addr[C_PC] = store_prog_pc_i;
	assign cls_addr[C_TGT] = store_prog_addr_i;
	assign cls_addr[C_LDPC] = load_pc_i;
	assign cls_addr[C_LDA] = load_addr_i;
	assign cls_addr[C_FET] = fetch_addr_i;

	genvar gi;
	generate
		for (gi = 0; gi < NCLS; gi++) begin : g_cls
			fsp_addr_class #(
				.AW(AW),
				.FLASH_WORDS(FLASH_WORDS),
				.BOOT_MIN_WORDS(BOOT_MIN_WORDS),
				.RWW_LIMIT(RWW_LIMIT)
			) u_cls (
				.boot_size_fuses_i(boot_size_fuses_i),
				.addr_i(cls_addr[gi]),
				.in_boot_o(cls_boot[gi]),
				.in_stall_o(cls_stall[gi])
			);
		end
	endgenerate

	// ****************************************************************
	// State
	// ****************************************************************
	fsp_state_type state_q;
	fsp_state_type state_d;
	logic [3:0] lock_q;
	logic [3:0] lock_d;
	logic busy_q;
	logic busy_d;
	logic stall_q;
	logic stall_d;
	logic prog_err_q;
	logic prog_err_d;
	logic read_err_q;
	logic read_err_d;
	logic erase_q;
	logic erase_d;
	logic write_q;
	logic write_d;
	logic [PW-1:0] page_q;
	logic [PW-1:0] page_d;
	logic [DW-1:0] rdata_q;
	logic [DW-1:0] rdata_d;

	logic tgt_wr_ok;
	logic accept;
	logic timer_done;
	logic wr_lock;
	logic wr_ctrl;
	logic ld_cross;

	// ****************************************************************
	// Store-program admission
	// ****************************************************************
	always_comb begin
		// Each target section consults only its own lock pair.
		if (cls_boot[C_TGT]) begin
			tgt_wr_ok = lock_q[LK_BOOT+LK_WR];
		end else begin
			tgt_wr_ok = lock_q[LK_APP+LK_WR];
		end
		accept = store_prog_req_i && state_q == FSP_IDLE
			&& cls_boot[C_PC] && tgt_wr_ok;
	end

	assign store_prog_ack_o = accept;
	assign store_prog_reject_o = store_prog_req_i && !accept;
	assign store_prog_done_o = timer_done;

	fsp_op_timer #(
		.CW(OP_CW),
		.CYCLES(OP_CYCLES)
	) u_timer (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.start_i(accept),
		.busy_o(),
		.done_o(timer_done)
	);

	// ****************************************************************
	// Reads of program memory and code fetches
	// ****************************************************************
	always_comb begin
		// Reads crossing between sections obey the target's read lock.
		ld_cross = 1'b0;
		if (cls_boot[C_LDPC] && !cls_boot[C_LDA]) begin
			ld_cross = !lock_q[LK_APP+LK_RD];
		end else if (!cls_boot[C_LDPC] && cls_boot[C_LDA]) begin
			ld_cross = !lock_q[LK_BOOT+LK_RD];
		end
		load_deny_o = load_req_i && (ld_cross
			|| (busy_q && !cls_stall[C_LDA]));
	end

	// Fetches are never checked against page boundaries, only regions.
	assign fetch_grant_o = fetch_req_i && !stall_q
		&& !(busy_q && !cls_stall[C_FET]);
	assign fetch_violation_o = fetch_req_i && busy_q
		&& !cls_stall[C_FET];

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	assign wr_lock = reg_wr_i && reg_addr_i == REG_LOCK;
	assign wr_ctrl = reg_wr_i && reg_addr_i == REG_CTRL;

	always_comb begin
		state_d = state_q;
		lock_d = lock_q;
		busy_d = busy_q;
		stall_d = stall_q;
		prog_err_d = prog_err_q;
		read_err_d = read_err_q;
		erase_d = erase_q;
		write_d = write_q;
		page_d = page_q;
		rdata_d = '0;
		unique case (state_q)
			FSP_IDLE: begin
				if (accept) begin
					state_d = FSP_BUSY;
					erase_d = store_prog_op_i == FSP_ERASE;
					write_d = store_prog_op_i == FSP_WRITE;
					page_d = store_prog_addr_i[AW-1:PAGE_SH];
					// The target page, not the fetch, picks the stall.
					stall_d = cls_stall[C_TGT];
				end
			end
			FSP_BUSY: begin
				if (timer_done) begin
					state_d = FSP_IDLE;
					erase_d = 1'b0;
					write_d = 1'b0;
					stall_d = 1'b0;
				end
			end
		endcase
		// Lock bits can only be programmed (cleared) by software.
		if (wr_lock) begin
			lock_d = lock_q & reg_wdata_i[3:0];
		end
		// A clear while an operation runs is ignored; a set wins.
		if (wr_ctrl && reg_wdata_i[CT_CLR_BUSY]
			&& state_q == FSP_IDLE) begin
			busy_d = 1'b0;
		end
		if (accept && !cls_stall[C_TGT]) begin
			busy_d = 1'b1;
		end
		if (wr_ctrl && reg_wdata_i[CT_CLR_ERR]) begin
			prog_err_d = 1'b0;
			read_err_d = 1'b0;
		end
		if (store_prog_reject_o) begin
			prog_err_d = 1'b1;
		end
		if (load_deny_o || fetch_violation_o) begin
			read_err_d = 1'b1;
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				REG_STATUS: begin
					rdata_d[ST_BUSY] = busy_q;
					rdata_d[ST_ACTIVE] = state_q == FSP_BUSY;
					rdata_d[ST_STALL] = stall_q;
					rdata_d[ST_PROG_ERR] = prog_err_q;
					rdata_d[ST_READ_ERR] = read_err_q;
				end
				REG_LOCK: rdata_d[3:0] = lock_q;
				REG_FUSE: rdata_d[1:0] = boot_size_fuses_i;
				default: rdata_d = '0;
			endcase
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= FSP_IDLE;
			lock_q <= LOCK_RESET;
			busy_q <= 1'b0;
			stall_q <= 1'b0;
			prog_err_q <= 1'b0;
			read_err_q <= 1'b0;
			erase_q <= 1'b0;
			write_q <= 1'b0;
			page_q <= '0;
			rdata_q <= '0;
		end else begin
			state_q <= state_d;
			lock_q <= lock_d;
			busy_q <= busy_d;
			stall_q <= stall_d;
			prog_err_q <= prog_err_d;
			read_err_q <= read_err_d;
			erase_q <= erase_d;
			write_q <= write_d;
			page_q <= page_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign flash_erase_o = erase_q;
	assign flash_write_o = write_q;
	assign flash_page_o = page_q;
	assign cpu_stall_o = stall_q;
	assign concurrent_region_busy_flag_o = busy_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	chk_app_no_start: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		store_prog_req_i && !cls_boot[C_PC]
		|-> !store_prog_ack_o && store_prog_reject_o)
		else $error("Store-program from application was accepted.");

	chk_boot_start: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		store_prog_req_i && state_q == FSP_IDLE && cls_boot[C_PC]
		&& (cls_boot[C_TGT] ? lock_q[LK_BOOT+LK_WR] : lock_q[LK_APP+LK_WR])
		|-> store_prog_ack_o)
		else $error("Legal store-program from boot was refused.");

	chk_app_lock: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		store_prog_ack_o && !cls_boot[C_TGT]
		|-> lock_q[LK_APP+LK_WR])
		else $error("Locked application page was programmed.");

	chk_boot_lock: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		store_prog_ack_o && cls_boot[C_TGT]
		|-> lock_q[LK_BOOT+LK_WR])
		else $error("Locked boot page was programmed.");

	chk_lock_indep: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		wr_lock && reg_wdata_i[3:2] == 2'b11
		|=> lock_q[3:2] == $past(lock_q[3:2]))
		else $error("Boot lock changed by application lock write.");

	chk_stall_hold: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		store_prog_ack_o && cls_stall[C_TGT]
		|=> cpu_stall_o[*8])
		else $error("CPU stall dropped during stalling-region op.");

	chk_op_length: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		store_prog_ack_o |-> ##[400:400] store_prog_done_o)
		else $error("Page operation did not end on time.");

	chk_stall_release: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		store_prog_done_o |=> !cpu_stall_o && state_q == FSP_IDLE)
		else $error("Stall not released after page operation.");

	chk_conc_no_stall: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		store_prog_ack_o && !cls_stall[C_TGT]
		|=> !cpu_stall_o && concurrent_region_busy_flag_o)
		else $error("Concurrent-region op stalled or left flag low.");

	chk_page_stable: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		state_q == FSP_BUSY && !timer_done |=> $stable(flash_page_o))
		else $error("Page address moved during an operation.");

endmodule

/* File: fsp_pkg.sv */
// Shared constants and types of the flash self-programming controller.
package fsp_pkg;

	// ****************************************************************
	// Widths and flash geometry
	// ****************************************************************
	localparam int AW = 14;
	localparam int DW = 8;
	localparam int RAW = 4;
	localparam int FLASH_WORDS = 16384;
	localparam int BOOT_MIN_WORDS = 256;
	localparam int RWW_LIMIT = 14336;
	localparam int PAGE_WORDS = 64;
	localparam int PAGE_SH = $clog2(PAGE_WORDS);

	// ****************************************************************
	// Register map and fields
	// ****************************************************************
	localparam logic [RAW-1:0] REG_STATUS = 4'h0;
	localparam logic [RAW-1:0] REG_LOCK = 4'h1;
	localparam logic [RAW-1:0] REG_CTRL = 4'h2;
	localparam logic [RAW-1:0] REG_FUSE = 4'h3;
	localparam int ST_BUSY = 0;
	localparam int ST_ACTIVE = 1;
	localparam int ST_STALL = 2;
	localparam int ST_PROG_ERR = 3;
	localparam int ST_READ_ERR = 4;
	localparam int LK_APP = 0;
	localparam int LK_BOOT = 2;
	localparam int LK_WR = 0;
	localparam int LK_RD = 1;
	localparam int CT_CLR_BUSY = 0;
	localparam int CT_CLR_ERR = 1;
	localparam logic [3:0] LOCK_RESET = 4'hF;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int OP_TIME_NS = 4000;
	localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int OP_CW = 16;

	typedef enum logic {
		FSP_ERASE,
		FSP_WRITE
	} fsp_op_type;

endpackage

/* File: fsp_addr_class.sv */
// Classifies one flash word address into sections and fixed regions.
`timescale 1ns/1ps
module fsp_addr_class #(
	parameter int AW = fsp_pkg::AW,
	parameter int FLASH_WORDS = fsp_pkg::FLASH_WORDS,
	parameter int BOOT_MIN_WORDS = fsp_pkg::BOOT_MIN_WORDS,
	parameter int RWW_LIMIT = fsp_pkg::RWW_LIMIT
) (
	input wire logic [1:0] boot_size_fuses_i,
	input wire logic [AW-1:0] addr_i,
	output logic in_boot_o,
	output logic in_stall_o
);
	import fsp_pkg::*;

	logic [AW:0] boot_words;
	logic [AW:0] boot_start;

	// Each step down of the fuse value doubles the boot code section.
	always_comb begin
		boot_words = (AW+1)'(BOOT_MIN_WORDS) << (~boot_size_fuses_i);
		boot_start = (AW+1)'(FLASH_WORDS) - boot_words;
	end

	assign in_boot_o = {1'b0, addr_i} >= boot_start;
	assign in_stall_o = addr_i >= AW'(RWW_LIMIT);

endmodule

/* File: fsp_op_timer.sv */
// Down-counter that times one page erase or page write.
`timescale 1ns/1ps
module fsp_op_timer #(
	parameter int CW = fsp_pkg::OP_CW,
	parameter int CYCLES = fsp_pkg::OP_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	output logic busy_o,
	output logic done_o
);
	import fsp_pkg::*;

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (start_i) begin
			cnt_d = CW'(CYCLES);
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign busy_o = cnt_q != '0;
	assign done_o = cnt_q == CW'(1);

endmodule

/* File: fsp_cpu_model.sv */
// CPU core model that issues store-program operations and fetches code.
`timescale 1ns/1ps
module fsp_cpu_model (
	input wire logic issue_i,
	input wire fsp_pkg::fsp_op_type issue_op_i,
	input wire logic [fsp_pkg::AW-1:0] issue_pc_i,
	input wire logic [fsp_pkg::AW-1:0] issue_addr_i,
	input wire logic [fsp_pkg::AW-1:0] fetch_target_i,
	input wire logic rogue_i,
	input wire logic stall_i,
	input wire logic busy_flag_i,
	output logic store_prog_req_o,
	output fsp_pkg::fsp_op_type store_prog_op_o,
	output logic [fsp_pkg::AW-1:0] store_prog_pc_o,
	output logic [fsp_pkg::AW-1:0] store_prog_addr_o,
	output logic fetch_req_o,
	output logic [fsp_pkg::AW-1:0] fetch_addr_o
);
	import fsp_pkg::*;
	// ****************************************************************
	// Execution and fetch
	// ****************************************************************
	// A halted core executes nothing, so no store-program request leaves it while stalled; fetch requests stay on.
	assign store_prog_req_o = issue_i && !stall_i;
	assign store_prog_op_o = issue_op_i;
	assign store_prog_pc_o = issue_pc_i;
	assign store_prog_addr_o = issue_addr_i;
	assign fetch_req_o = 1'b1;
	// Careful software runs from the stalling region while the other is
	// busy; rogue_i lets a test break that on purpose.
	always_comb begin
		fetch_addr_o = fetch_target_i;
		if (busy_flag_i && !rogue_i
			&& fetch_target_i < AW'(RWW_LIMIT)) begin
			fetch_addr_o = AW'(RWW_LIMIT);
		end
	end
endmodule

/* File: tb_top.sv */
// Self-checking testbench of the flash self-programming controller.
`timescale 1ns/1ps
module tb_top;
	import fsp_pkg::*;
	typedef struct {
		logic [1:0] fuse;
		fsp_op_type op;
		logic [13:0] pc;
		logic [13:0] addr;
		logic ack;
	} fsp_row_type;
	fsp_row_type rows [6] = '{
		'{2'h3, FSP_ERASE, 14'h3F00, 14'h0040, 1'b1},
		'{2'h3, FSP_ERASE, 14'h3EFF, 14'h0040, 1'b0},
		'{2'h0, FSP_WRITE, 14'h3800, 14'h3F80, 1'b1},
		'{2'h1, FSP_WRITE, 14'h3BFF, 14'h3F80, 1'b0},
		'{2'h2, FSP_WRITE, 14'h3E00, 14'h37FF, 1'b1},
		'{2'h1, FSP_ERASE, 14'h3C00, 14'h3800, 1'b1}};
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [1:0] fuse = 2'h3;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic iss = 1'b0;
	fsp_op_type iss_op = FSP_ERASE;
	logic [13:0] iss_pc = 14'h0000;
	logic [13:0] iss_addr = 14'h0000;
	logic [13:0] target = 14'h3800;
	logic rogue = 1'b0;
	logic load_req = 1'b0;
	logic [13:0] load_pc = 14'h3F00;
	logic [13:0] load_addr = 14'h3800;
	logic [7:0] reg_rdata, page;
	logic [13:0] sp_pc, sp_addr, f_addr;
	fsp_op_type sp_op;
	logic sp_req, sp_ack, sp_rej, sp_done, ld_deny, f_req, f_grant, f_viol;
	logic er, wr, stall, busy, got_ack, got_rej;
	int errors = 0;
	int check_count = 0;
	int cyc = 0;
	int t0 = 0;

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) cyc <= cyc + 1;

	fsp_self_prog fsp_self_prog_i (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .boot_size_fuses_i(fuse),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
		.reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
		.store_prog_req_i(sp_req), .store_prog_op_i(sp_op),
		.store_prog_pc_i(sp_pc), .store_prog_addr_i(sp_addr),
		.store_prog_ack_o(sp_ack), .store_prog_reject_o(sp_rej),
		.store_prog_done_o(sp_done), .load_req_i(load_req),
		.load_pc_i(load_pc), .load_addr_i(load_addr), .load_deny_o(ld_deny),
		.fetch_req_i(f_req), .fetch_addr_i(f_addr), .fetch_grant_o(f_grant),
		.fetch_violation_o(f_viol), .flash_erase_o(er), .flash_write_o(wr),
		.flash_page_o(page), .cpu_stall_o(stall),
		.concurrent_region_busy_flag_o(busy)
	);
	fsp_cpu_model fsp_cpu_model_i (
		.issue_i(iss), .issue_op_i(iss_op), .issue_pc_i(iss_pc),
		.issue_addr_i(iss_addr), .fetch_target_i(target), .rogue_i(rogue),
		.stall_i(stall), .busy_flag_i(busy), .store_prog_req_o(sp_req),
		.store_prog_op_o(sp_op), .store_prog_pc_o(sp_pc),
		.store_prog_addr_o(sp_addr), .fetch_req_o(f_req), .fetch_addr_o(f_addr)
	);

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic do_reset();
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
	endtask
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_i);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic expect_reg(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_i);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask
	task automatic issue(input fsp_op_type op, input logic [13:0] pc,
		input logic [13:0] a);
		@(posedge clk_i);
		iss <= 1'b1;
		iss_op <= op;
		iss_pc <= pc;
		iss_addr <= a;
		#1;
		got_ack = sp_ack;
		got_rej = sp_rej;
		if (sp_ack === 1'b1) t0 = cyc;
		@(posedge clk_i);
		iss <= 1'b0;
		#1;
	endtask
	task automatic drive_cpu(input logic [13:0] t, input logic rg,
		input logic [13:0] lp, input logic [13:0] la);
		@(posedge clk_i);
		target <= t;
		rogue <= rg;
		load_req <= 1'b1;
		load_pc <= lp;
		load_addr <= la;
		#1;
	endtask
	// A limit that runs out ends the run at once, so a hang cannot hide.
	task automatic wait_done();
		int n;
		n = 0;
		while (sp_done !== 1'b1 && n < 1000) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (sp_done !== 1'b1) begin
			errors++;
			final_report();
		end
	endtask

	// ****************************************************************
	// One store-program row: accept or refuse, then the whole operation
	// ****************************************************************
	task automatic run_row(input fsp_row_type r);
		logic st;
		st = (r.addr >= RWW_LIMIT);
		@(posedge clk_i);
		fuse <= r.fuse;
		issue(r.op, r.pc, r.addr);
		check(got_ack, r.ack);
		check(got_rej, !r.ack);
		if (!r.ack) begin
			expect_reg(REG_STATUS, 8'h08);
			reg_write(REG_CTRL, 8'h02);
			expect_reg(REG_STATUS, 8'h00);
			return;
		end
		check({er, wr}, r.op == FSP_ERASE ? 2'b10 : 2'b01);
		check(page, r.addr >> PAGE_SH);
		check(stall, st);
		check(busy, !st);
		drive_cpu(14'h3800, 1'b0, 14'h3F00, 14'h0000);
		if (st) begin
			check(f_grant, 1'b0);
			expect_reg(REG_STATUS, 8'h06);
		end else begin
			check({f_grant, ld_deny}, 2'b11);
			drive_cpu(14'h3800, 1'b0, 14'h3F00, 14'h3800);
			check({f_grant, ld_deny}, 2'b10);
			issue(FSP_WRITE, 14'h3F00, 14'h0000);
			check(got_rej, 1'b1);
			reg_write(REG_CTRL, 8'h03);
			expect_reg(REG_STATUS, 8'h03);
		end
		wait_done();
		check(16'(cyc - t0), OP_CYCLES);
		@(posedge clk_i);
		#1;
		check({er, wr, stall}, 3'b000);
		if (!st) begin
			drive_cpu(14'h0000, 1'b1, 14'h3F00, 14'h3800);
			check({busy, f_grant, f_viol}, 3'b101);
			drive_cpu(14'h3800, 1'b0, 14'h3F00, 14'h3800);
			reg_write(REG_CTRL, 8'h03);
			expect_reg(REG_STATUS, 8'h00);
			drive_cpu(14'h0000, 1'b1, 14'h3F00, 14'h3800);
			check({f_grant, f_viol}, 2'b10);
		end
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		do_reset();
		expect_reg(REG_STATUS, 8'h00);
		for (int i = 0; i < 6; i++) begin
			run_row(rows[i]);
			$display("row %0d done", i);
		end
		@(posedge clk_i);
		fuse <= 2'h3;
		expect_reg(REG_FUSE, 8'h03);
		expect_reg(REG_LOCK, 8'h0F);
		expect_reg(4'h7, 8'h00);
		reg_write(REG_LOCK, 8'h0E);
		issue(FSP_ERASE, 14'h3F00, 14'h0000);
		check(got_rej, 1'b1);
		issue(FSP_ERASE, 14'h3F00, 14'h3F40);
		check(got_ack, 1'b1);
		wait_done();
		reg_write(REG_LOCK, 8'h0B);
		expect_reg(REG_LOCK, 8'h0A);
		issue(FSP_ERASE, 14'h3F00, 14'h3F40);
		check(got_rej, 1'b1);
		reg_write(REG_LOCK, 8'h08);
		drive_cpu(14'h3800, 1'b0, 14'h3F00, 14'h0100);
		check(ld_deny, 1'b1);
		drive_cpu(14'h3800, 1'b0, 14'h0100, 14'h3F10);
		check(ld_deny, 1'b0);
		reg_write(REG_LOCK, 8'h00);
		check(ld_deny, 1'b1);
		$display("lock test done");
		do_reset();
		expect_reg(REG_LOCK, 8'h0F);
		issue(FSP_WRITE, 14'h3F00, 14'h3F40);
		check(stall, 1'b1);
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		#1;
		check({er, wr, stall}, 3'b000);
		do_reset();
		expect_reg(REG_STATUS, 8'h00);
		$display("reset test done");
		final_report();
	end
endmodule
